// >>> src/power_down_pkg.sv
package power_down_pkg;
  // ***************************************
  // Device register indices and widths
  // ***************************************
  localparam int         REG_DW      = 16;
  localparam int         IDX_W       = 4;
  localparam logic [3:0] IDX_VC1     = 4'h0;
  localparam logic [3:0] IDX_VC2     = 4'h1;
  localparam logic [3:0] IDX_VC3     = 4'h2;
  localparam logic [3:0] IDX_AUX1    = 4'h3;
  localparam logic [3:0] IDX_AUX2    = 4'h4;
  localparam logic [3:0] IDX_PR1     = 4'h5;
  localparam logic [3:0] IDX_PR2     = 4'h6;
  localparam logic [3:0] IDX_STAT_LO = 4'h7;
  localparam logic [3:0] IDX_STAT_HI = 4'h8;
  localparam int VC1_W = 1;
  localparam int VC2_W = 1;
  localparam int VC3_W = 4;
  localparam int AUX1_W = 4;
  localparam int AUX2_W = 4;
  localparam int PR1_W = 6;
  localparam int PR2_W = 7;
  // ***************************************
  // Field positions
  // ***************************************
  localparam int VC1_UL_ON = 0;
  localparam int VC2_DL_ON = 0;
  localparam int VC3_IF_EN = 0;
  localparam int VC3_CLK_START = 1;
  localparam int VC3_PATH_LSB = 2;
  localparam int PATH_W = 2;
  localparam int AUX2_PCTL_SEL = 0;
  localparam int AUX2_PCTL_EN = 1;
  localparam int AUX2_GAIN_SEL = 2;
  localparam int AUX2_GAIN_EN = 3;
  localparam int PR1_BBUL_SEL = 0;
  localparam int PR1_BBUL_EN = 1;
  localparam int PR1_BBDL_SEL = 2;
  localparam int PR1_BBDL_EN = 3;
  localparam int PR1_CM_SEL = 4;
  localparam int PR1_CM_EN = 5;
  localparam int AUX1_ACONV_SEL = 0;
  localparam int AUX1_ACONV_EN = 1;
  localparam int AUX1_FREQ_SEL = 2;
  localparam int AUX1_FREQ_EN = 3;
  localparam int PR2_DSP_SEL = 0;
  localparam int PR2_DSP_EN = 1;
  localparam int PR2_TIM_SEL = 2;
  localparam int PR2_TIM_EN = 3;
  localparam int PR2_REF_SEL = 4;
  localparam int PR2_REF_EN = 5;
  localparam int PR2_BG_SEL = 6;
  // Test path codes
  localparam logic [1:0] PATH_IDLE = 2'h0;
  localparam logic [1:0] PATH_ACOUSTIC = 2'h1;
  localparam logic [1:0] PATH_DECODER = 2'h2;
  localparam logic [1:0] PATH_ENCODER = 2'h3;
  // Reset values
  localparam logic [VC1_W-1:0] VC1_RST = 1'h0;
  localparam logic [VC2_W-1:0] VC2_RST = 1'h0;
  localparam logic [VC3_W-1:0] VC3_RST = 4'h0;
  localparam logic [AUX1_W-1:0] AUX1_RST = 4'h0;
  localparam logic [AUX2_W-1:0] AUX2_RST = 4'h0;
  localparam logic [PR1_W-1:0] PR1_RST = 6'h00;
  localparam logic [PR2_W-1:0] PR2_RST = 7'h00;
  // ***************************************
  // Power enable vector
  // ***************************************
  localparam int PWR_VUL = 0;
  localparam int PWR_VDL = 1;
  localparam int PWR_AIF = 2;
  localparam int PWR_PCTL = 3;
  localparam int PWR_BBUL = 4;
  localparam int PWR_CM = 5;
  localparam int PWR_GAIN = 6;
  localparam int PWR_BBDL = 7;
  localparam int PWR_DSP = 8;
  localparam int PWR_TIM = 9;
  localparam int PWR_ACONV = 10;
  localparam int PWR_FREQ = 11;
  localparam int PWR_MIC = 12;
  localparam int PWR_BG = 13;
  localparam int PWR_IREF = 14;
  localparam int PWR_SUL_BUF = 15;
  localparam int PWR_SDL_BUF = 16;
  localparam int PWR_MDL_BUF = 17;
  localparam int PWR_N = 18;
  localparam int NWIN = 5;
  localparam int NPIN = 5;
  // Line order on the link and in the synchroniser
  localparam int LINE_TX = 0;
  localparam int LINE_RX = 1;
  localparam int LINE_PD = 2;
  localparam int LINE_RSTL = 3;
  localparam int LINE_N = 4;
  localparam int AUDIO_HALF_DIV_DEF = 50;
  // ***************************************
  // Controller registers and commands
  // ***************************************
  localparam logic [3:0] HOST_PINS = 4'h0;
  localparam logic [3:0] HOST_DATA = 4'h1;
  localparam logic [3:0] HOST_CMD = 4'h2;
  localparam logic [3:0] HOST_STATUS = 4'h3;
  localparam logic [3:0] HOST_RDDATA = 4'h4;
  localparam int CMD_OP_LSB = 4;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_ACOUSTIC = 2'h2;
  localparam logic [1:0] OP_VOCODER = 2'h3;
  localparam int SEQ_W = 3;
  localparam logic [2:0] SEQ_CLEAR_LAST = 3'h2;
  localparam logic [2:0] SEQ_LAST_ACOUSTIC = 3'h6;
  localparam logic [2:0] SEQ_LAST_VOCODER = 3'h3;
endpackage

// >>> src/power_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface power_link_if;
  import power_down_pkg::*;
  logic [IDX_W-1:0]  regIndex;
  logic [REG_DW-1:0] regWdata;
  logic              regWrite;
  logic              regRead;
  logic [REG_DW-1:0] regRdata;
  logic              txWindow;
  logic              rxWindow;
  logic              powerDown;
  logic              audioResetLine;
  modport device (
    input  regIndex,
    input  regWdata,
    input  regWrite,
    input  regRead,
    output regRdata,
    input  txWindow,
    input  rxWindow,
    input  powerDown,
    input  audioResetLine
  );
  modport host (
    output regIndex,
    output regWdata,
    output regWrite,
    output regRead,
    input  regRdata,
    output txWindow,
    output rxWindow,
    output powerDown,
    output audioResetLine
  );
endinterface
`default_nettype wire

// >>> src/level_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync3
  import power_down_pkg::*;
#(
  parameter int W = LINE_N
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_t;
  sync_t syncReg;
  sync_t syncNext;

  // Level moves only when second and third stage agree
  always_comb begin
    syncNext = syncReg;
    syncNext.s1 = din;
    syncNext.s2 = syncReg.s1;
    syncNext.s3 = syncReg.s2;
    syncNext.lvl = (syncReg.s2 & syncReg.s3) | (syncReg.lvl & (syncReg.s2 | syncReg.s3));
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign dout = syncReg.lvl;
endmodule // level_sync3
`default_nettype wire

// >>> src/power_down_control.sv
// Contract
// R1 - Audio test interface active only when enabled
// R2 - Voice paths follow their on bits only
// R3 - Window select 0: window and enable gate
// R4 - Window function off while its enable is 0
// R5 - Transmit window gates power, uplink, common-mode
// R6 - Receive window gates gain DAC, downlink
// R7 - Pin select 0: power-down pin and enable
// R8 - High on power-down pin requests power down
// R9 - Pin function off while its enable is 0
// R10 - Five pin functions, own select and enable
// R11 - Band gap has select only, no enable
// R12 - Software clears three bits before tests
// R13 - Acoustic test sets four bits in order
// R14 - Vocoder test sets two bits together
// R15 - Clock start runs clock, cleared on fall
// R16 - Two-bit field routes three test paths
// R17 - Current reference follows band gap control
// R18 - Speech buffers follow blocks, modem follows window
// R19 - Terminals synchronised before combining with bits
`timescale 1ns/1ps
`default_nettype none
module power_down_control
  import power_down_pkg::*;
#(
  parameter int AUDIO_HALF_DIV = AUDIO_HALF_DIV_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  power_link_if.device     link,
  output logic [PWR_N-1:0] powerEnable,
  output logic             audioTestSerialClock,
  output logic [1:0]       audioTestPathSelect,
  output logic             audioRouteUplink,
  output logic             audioRouteDownlink
);
  localparam int DIV_W = $clog2(AUDIO_HALF_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(AUDIO_HALF_DIV - 1);

  typedef struct packed {
    logic [VC1_W-1:0]  vc1;
    logic [VC2_W-1:0]  vc2;
    logic [VC3_W-1:0]  vc3;
    logic [AUX1_W-1:0] aux1;
    logic [AUX2_W-1:0] aux2;
    logic [PR1_W-1:0]  pr1;
    logic [PR2_W-1:0]  pr2;
    logic [PWR_N-1:0]  pwr;
    logic [REG_DW-1:0] rdata;
    logic              rstPrev;
    logic [DIV_W-1:0]  divCnt;
    logic              sclk;
    logic [1:0]        path;
    logic              routeUl;
    logic              routeDl;
  } state_t;
  state_t stReg;
  state_t stNext;

  // ***************************************
  // Terminal synchronisation
  // ***************************************
  logic [LINE_N-1:0] lineRaw;
  logic [LINE_N-1:0] lineLvl;
  assign lineRaw[LINE_TX] = link.txWindow;
  assign lineRaw[LINE_RX] = link.rxWindow;
  assign lineRaw[LINE_PD] = link.powerDown;
  assign lineRaw[LINE_RSTL] = link.audioResetLine;

  // Filtered levels keep pin noise out of the enables
  level_sync3 #(.W(LINE_N)) u_sync (  // see R19
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .din     (lineRaw),
    .dout    (lineLvl)
  );

  logic txLvl;
  logic rxLvl;
  logic pdLvl;
  assign txLvl = lineLvl[LINE_TX];
  assign rxLvl = lineLvl[LINE_RX];
  assign pdLvl = lineLvl[LINE_PD];  // see R8

  // ***************************************
  // Window and pin controlled functions
  // ***************************************
  logic [NWIN-1:0] winSel;
  logic [NWIN-1:0] winEn;
  logic [NWIN-1:0] winGate;
  logic [NWIN-1:0] winOn;
  logic [NPIN-1:0] pinSel;
  logic [NPIN-1:0] pinEn;
  logic [NPIN-1:0] pinOn;

  // Order: power ctl, bb uplink, common mode, gain ctl, bb downlink
  assign winSel = {stReg.pr1[PR1_BBDL_SEL], stReg.aux2[AUX2_GAIN_SEL],
                   stReg.pr1[PR1_CM_SEL], stReg.pr1[PR1_BBUL_SEL],
                   stReg.aux2[AUX2_PCTL_SEL]};
  assign winEn = {stReg.pr1[PR1_BBDL_EN], stReg.aux2[AUX2_GAIN_EN],
                  stReg.pr1[PR1_CM_EN], stReg.pr1[PR1_BBUL_EN],
                  stReg.aux2[AUX2_PCTL_EN]};
  assign winGate = {rxLvl, rxLvl, txLvl, txLvl, txLvl};  // see R5 see R6

  // Order: dsp serial, timing, aux conv, freq ctl, mic bias buffer
  assign pinSel = {stReg.pr2[PR2_REF_SEL], stReg.aux1[AUX1_FREQ_SEL],
                   stReg.aux1[AUX1_ACONV_SEL], stReg.pr2[PR2_TIM_SEL],
                   stReg.pr2[PR2_DSP_SEL]};  // see R10
  assign pinEn = {stReg.pr2[PR2_REF_EN], stReg.aux1[AUX1_FREQ_EN],
                  stReg.aux1[AUX1_ACONV_EN], stReg.pr2[PR2_TIM_EN],
                  stReg.pr2[PR2_DSP_EN]};

  // Enable 0 always wins, select 1 drops the terminal
  for (genvar i = 0; i < NWIN; i++) begin : g_win
    assign winOn[i] = winEn[i] & (winSel[i] | winGate[i]);  // see R3 see R4
  end
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    assign pinOn[i] = pinEn[i] & (pinSel[i] | ~pdLvl);  // see R7 see R9
  end

  // Band gap has no enable bit, only the pin select
  logic bgOn;
  assign bgOn = stReg.pr2[PR2_BG_SEL] | ~pdLvl;  // see R11

  // Falling edge of the filtered audio reset line
  logic rstFall;
  assign rstFall = stReg.rstPrev & ~lineLvl[LINE_RSTL];

  // ***************************************
  // Register file and power enables
  // ***************************************
  always_comb begin
    stNext = stReg;
    stNext.rdata = '0;
    stNext.rstPrev = lineLvl[LINE_RSTL];
    if (link.regWrite) begin
      case (link.regIndex)
        IDX_VC1: stNext.vc1 = link.regWdata[VC1_W-1:0];
        IDX_VC2: stNext.vc2 = link.regWdata[VC2_W-1:0];
        IDX_VC3: stNext.vc3 = link.regWdata[VC3_W-1:0];
        IDX_AUX1: stNext.aux1 = link.regWdata[AUX1_W-1:0];
        IDX_AUX2: stNext.aux2 = link.regWdata[AUX2_W-1:0];
        IDX_PR1: stNext.pr1 = link.regWdata[PR1_W-1:0];
        IDX_PR2: stNext.pr2 = link.regWdata[PR2_W-1:0];
        default: stNext.rdata = '0;
      endcase
    end
    // Hardware clear beats a same-cycle software set
    if (rstFall) begin
      stNext.vc3[VC3_CLK_START] = 1'b0;  // see R15
    end
    if (link.regRead) begin
      case (link.regIndex)
        IDX_VC1: stNext.rdata = REG_DW'(stReg.vc1);
        IDX_VC2: stNext.rdata = REG_DW'(stReg.vc2);
        IDX_VC3: stNext.rdata = REG_DW'(stReg.vc3);
        IDX_AUX1: stNext.rdata = REG_DW'(stReg.aux1);
        IDX_AUX2: stNext.rdata = REG_DW'(stReg.aux2);
        IDX_PR1: stNext.rdata = REG_DW'(stReg.pr1);
        IDX_PR2: stNext.rdata = REG_DW'(stReg.pr2);
        IDX_STAT_LO: stNext.rdata = stReg.pwr[REG_DW-1:0];
        IDX_STAT_HI: stNext.rdata = REG_DW'(stReg.pwr[PWR_N-1:REG_DW]);
        default: stNext.rdata = '0;  // Unmapped reads give zero
      endcase
    end
    // Voice paths ignore every terminal
    stNext.pwr[PWR_VUL] = stReg.vc1[VC1_UL_ON];  // see R2
    stNext.pwr[PWR_VDL] = stReg.vc2[VC2_DL_ON];  // see R2
    stNext.pwr[PWR_AIF] = stReg.vc3[VC3_IF_EN];  // see R1
    stNext.pwr[PWR_PCTL] = winOn[0];
    stNext.pwr[PWR_BBUL] = winOn[1];
    stNext.pwr[PWR_CM] = winOn[2];
    stNext.pwr[PWR_GAIN] = winOn[3];
    stNext.pwr[PWR_BBDL] = winOn[4];
    stNext.pwr[PWR_DSP] = pinOn[0];
    stNext.pwr[PWR_TIM] = pinOn[1];
    stNext.pwr[PWR_ACONV] = pinOn[2];
    stNext.pwr[PWR_FREQ] = pinOn[3];
    stNext.pwr[PWR_MIC] = pinOn[4];
    stNext.pwr[PWR_BG] = bgOn;
    stNext.pwr[PWR_IREF] = bgOn;  // see R17
    stNext.pwr[PWR_SUL_BUF] = stReg.vc1[VC1_UL_ON];  // see R18
    stNext.pwr[PWR_SDL_BUF] = stReg.vc2[VC2_DL_ON];  // see R18
    stNext.pwr[PWR_MDL_BUF] = rxLvl;  // see R18
    // Serial clock needs both the interface and the start bit
    if (stReg.vc3[VC3_IF_EN] && stReg.vc3[VC3_CLK_START]) begin  // see R15
      if (stReg.divCnt == DIV_LAST) begin
        stNext.divCnt = '0;
        stNext.sclk = ~stReg.sclk;
      end else begin
        stNext.divCnt = stReg.divCnt + DIV_W'(1);
      end
    end else begin
      stNext.divCnt = '0;
      stNext.sclk = 1'b0;
    end
    // Path routing is held idle while the interface sleeps
    stNext.path = stReg.vc3[VC3_IF_EN] ? stReg.vc3[VC3_PATH_LSB+:PATH_W] : PATH_IDLE;
    case (stNext.path)  // see R16
      PATH_ACOUSTIC: begin
        stNext.routeUl = 1'b1;
        stNext.routeDl = 1'b1;
      end
      PATH_DECODER: begin
        stNext.routeUl = 1'b0;
        stNext.routeDl = 1'b1;
      end
      PATH_ENCODER: begin
        stNext.routeUl = 1'b1;
        stNext.routeDl = 1'b0;
      end
      default: begin
        stNext.routeUl = 1'b0;
        stNext.routeDl = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stReg <= '0;
      stReg.vc1 <= VC1_RST;
      stReg.vc2 <= VC2_RST;
      stReg.vc3 <= VC3_RST;
      stReg.aux1 <= AUX1_RST;
      stReg.aux2 <= AUX2_RST;
      stReg.pr1 <= PR1_RST;
      stReg.pr2 <= PR2_RST;
    end else begin
      stReg <= stNext;
    end
  end

  // ***************************************
  // Outputs, all from flops
  // ***************************************
  assign link.regRdata = stReg.rdata;
  assign powerEnable = stReg.pwr;
  assign audioTestSerialClock = stReg.sclk;
  assign audioTestPathSelect = stReg.path;
  assign audioRouteUplink = stReg.routeUl;
  assign audioRouteDownlink = stReg.routeDl;
endmodule // power_down_control
`default_nettype wire

// >>> src/power_down_host.sv
`timescale 1ns/1ps
`default_nettype none
module power_down_host
  import power_down_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  power_link_if.host             link,
  input  wire logic [3:0]        addr,
  input  wire logic [REG_DW-1:0] wrData,
  input  wire logic              wrStrobe,
  input  wire logic              rdStrobe,
  output logic      [REG_DW-1:0] rdData
);
  typedef enum logic [1:0] {H_IDLE, H_SEQ, H_RD1, H_RD2} hstate_t;
  typedef struct packed {
    hstate_t           fsm;
    logic [LINE_N-1:0] pins;
    logic [REG_DW-1:0] data;
    logic              vocoder;
    logic [SEQ_W-1:0]  step;
    logic [REG_DW-1:0] lastRd;
    logic [REG_DW-1:0] rdData;
    logic [IDX_W-1:0]  idx;
    logic [REG_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } host_t;
  host_t hReg;
  host_t hNext;

  // Test start steps: three clears first, then the sets
  function automatic logic [IDX_W+REG_DW-1:0] seqWord(
    input logic [SEQ_W-1:0] step,
    input logic             voc,
    input logic [1:0]       path
  );
    logic [REG_DW-1:0] vc3;
    vc3 = REG_DW'({path, 2'h0});
    vc3[VC3_IF_EN] = 1'b1;
    case (step)
      3'h0: seqWord = {IDX_VC3, REG_DW'(0)};  // see R12
      3'h1: seqWord = {IDX_VC1, REG_DW'(0)};  // see R12
      3'h2: seqWord = {IDX_VC2, REG_DW'(0)};  // see R12
      3'h3: begin
        // Vocoder sets enable and start in one write
        vc3[VC3_CLK_START] = voc;  // see R14
        seqWord = {IDX_VC3, vc3};
      end
      3'h4: begin
        vc3[VC3_CLK_START] = 1'b1;  // see R13
        seqWord = {IDX_VC3, vc3};
      end
      3'h5: seqWord = {IDX_VC1, REG_DW'(1)};  // see R13
      3'h6: seqWord = {IDX_VC2, REG_DW'(1)};  // see R13
      default: seqWord = {IDX_VC3, REG_DW'(0)};
    endcase
  endfunction

  logic [1:0] op;
  logic [IDX_W+REG_DW-1:0] sw;
  assign op = wrData[CMD_OP_LSB+:2];
  assign sw = seqWord(hReg.step, hReg.vocoder, hReg.data[VC3_PATH_LSB+:PATH_W]);

  // ***************************************
  // Command decode and sequencing
  // ***************************************
  always_comb begin
    hNext = hReg;
    hNext.wr = 1'b0;
    hNext.rd = 1'b0;
    hNext.rdData = '0;
    if (wrStrobe) begin
      case (addr)
        HOST_PINS: hNext.pins = wrData[LINE_N-1:0];  // see R8
        HOST_DATA: hNext.data = wrData;
        default: hNext.rdData = '0;
      endcase
    end
    if (rdStrobe) begin
      case (addr)
        HOST_PINS: hNext.rdData = REG_DW'(hReg.pins);
        HOST_DATA: hNext.rdData = hReg.data;
        HOST_STATUS: hNext.rdData = REG_DW'(hReg.fsm != H_IDLE);
        HOST_RDDATA: hNext.rdData = hReg.lastRd;
        default: hNext.rdData = '0;
      endcase
    end
    case (hReg.fsm)
      H_IDLE: begin
        // Commands while busy are dropped
        if (wrStrobe && addr == HOST_CMD) begin
          hNext.idx = wrData[IDX_W-1:0];
          hNext.wdata = hReg.data;
          hNext.step = '0;
          hNext.vocoder = (op == OP_VOCODER);
          case (op)
            OP_WRITE: hNext.wr = 1'b1;
            OP_READ: begin
              hNext.rd = 1'b1;
              hNext.fsm = H_RD1;
            end
            default: hNext.fsm = H_SEQ;
          endcase
        end
      end
      H_SEQ: begin
        hNext.wr = 1'b1;
        hNext.idx = sw[IDX_W+REG_DW-1:REG_DW];
        hNext.wdata = sw[REG_DW-1:0];
        hNext.step = hReg.step + SEQ_W'(1);
        if (hReg.step == (hReg.vocoder ? SEQ_LAST_VOCODER : SEQ_LAST_ACOUSTIC)) begin
          hNext.fsm = H_IDLE;
        end
      end
      H_RD1: hNext.fsm = H_RD2;
      H_RD2: begin
        hNext.lastRd = link.regRdata;
        hNext.fsm = H_IDLE;
      end
      default: hNext.fsm = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hReg <= '0;
      hReg.fsm <= H_IDLE;
    end else begin
      hReg <= hNext;
    end
  end

  assign rdData = hReg.rdData;
  assign link.regIndex = hReg.idx;
  assign link.regWdata = hReg.wdata;
  assign link.regWrite = hReg.wr;
  assign link.regRead = hReg.rd;
  assign link.txWindow = hReg.pins[LINE_TX];
  assign link.rxWindow = hReg.pins[LINE_RX];
  assign link.powerDown = hReg.pins[LINE_PD];
  assign link.audioResetLine = hReg.pins[LINE_RSTL];
endmodule // power_down_host
`default_nettype wire

// >>> dv/power_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module power_link_checker
  import power_down_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic [IDX_W-1:0]  regIndex,
  input wire logic [REG_DW-1:0] regWdata,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [REG_DW-1:0] regRdata,
  input wire logic              powerDown,
  input wire logic              audioResetLine
);
  logic       wr0, wr1, wr2, lineReg;
  logic [3:0] pdLow, sinceFall;
  // Writes to the voice control registers
  assign wr0 = regWrite && regIndex == IDX_VC1;
  assign wr1 = regWrite && regIndex == IDX_VC2;
  assign wr2 = regWrite && regIndex == IDX_VC3;
  // Saturating age counters; sync latency needs some quiet cycles
  always_ff @(posedge sys_clk) begin
    lineReg <= audioResetLine;
    if (sys_rst || powerDown) pdLow <= 4'h0;
    else if (pdLow != 4'hF) pdLow <= pdLow + 4'h1;
    if (sys_rst || wr2 || audioResetLine) sinceFall <= 4'h0;
    else if (lineReg || (sinceFall != 4'h0 && sinceFall != 4'hF)) sinceFall <= sinceFall + 4'h1;
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence clearsSeq;
    wr2 && regWdata[1:0] == 2'h0 ##1 wr0 && !regWdata[0] ##1 wr1 && !regWdata[0];
  endsequence
  sequence armSeq;
    wr2 && regWdata[1:0] == 2'h1 ##1 wr2 && regWdata[1:0] == 2'h3;
  endsequence
  rdata_idle_a:
    assert property (!regRead |=> regRdata == '0) else $error("read data outside answer");
  unmapped_read_a:
    assert property (regRead && regIndex > IDX_STAT_HI |=> regRdata == '0)
    else $error("unmapped read not zero");
  narrow_read_a:
    assert property (regRead && regIndex == IDX_PR2 |=> regRdata[15:7] == '0)
    else $error("band gap has extra bits");
  bandgap_on_a:
    assert property (pdLow >= 4'hA && regRead && regIndex == IDX_STAT_LO
      |=> regRdata[PWR_BG] && regRdata[PWR_IREF]) else $error("reference off");
  start_clear_a:
    assert property (sinceFall >= 4'h9 && regRead && regIndex == IDX_VC3
      |=> !regRdata[VC3_CLK_START]) else $error("clock start not cleared");
  clears_first_a:
    assert property (clearsSeq |=> wr2 && regWdata[VC3_IF_EN]) else $error("bad test entry");
  acoustic_order_a:
    assert property (armSeq |=> wr0 && regWdata[0] ##1 wr1 && regWdata[0])
    else $error("acoustic order");
  enable_start_a:
    assert property (clearsSeq ##1 wr2 |-> (regWdata[VC3_CLK_START])
      or (##1 (wr2 && regWdata[VC3_CLK_START]))) else $error("start write missing");
endmodule // power_link_checker
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb
  import power_down_pkg::*;
;
  logic             sys_clk = 1'b0, sys_rst = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0;
  logic             polling = 1'b0, serClk, up, dn;
  logic [3:0]       addr = 4'h0, pinV = 4'h0;
  logic [15:0]      wrData = 16'h0000, rdData, regs [7], v, expQ [$], mskQ [$];
  logic [1:0]       pathSel, pth;
  logic [PWR_N-1:0] pwrEn;
  string            nameQ [$];
  int               checks = 0, miscompares = 0;
  int               wid [7] = '{VC1_W, VC2_W, VC3_W, AUX1_W, AUX2_W, PR1_W, PR2_W};
  power_link_if link ();
  power_down_host u_power_down_host (.sys_clk, .sys_rst, .link(link), .addr, .wrData,
    .wrStrobe, .rdStrobe, .rdData);
  power_down_control #(.AUDIO_HALF_DIV(2)) u_power_down_control (.sys_clk, .sys_rst,
    .link(link), .powerEnable(pwrEn), .audioTestSerialClock(serClk),
    .audioTestPathSelect(pathSel), .audioRouteUplink(up), .audioRouteDownlink(dn));
  power_link_checker u_power_link_checker (.sys_clk, .sys_rst, .regIndex(link.regIndex),
    .regWdata(link.regWdata), .regWrite(link.regWrite), .regRead(link.regRead),
    .regRdata(link.regRdata), .powerDown(link.powerDown),
    .audioResetLine(link.audioResetLine));
  initial forever #5 sys_clk = ~sys_clk;
  // ****************
  // Bus tasks
  // ****************
  task automatic hwr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic hrd(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge sys_clk);
    rdStrobe <= 1'b0;
  endtask
  // Busy polls bypass the scoreboard
  task automatic idle();
    polling = 1'b1;
    repeat (40) begin
      hrd(HOST_STATUS);
      @(negedge sys_clk);
      if (rdData[0] === 1'b0) break;
    end
    if (rdData[0] !== 1'b0) miscompares++;
    polling = 1'b0;
  endtask
  task automatic dev(input logic [1:0] op, input logic [3:0] i, input logic [15:0] d);
    if (op == OP_WRITE && i < 4'h7) regs[i] = d;
    hwr(HOST_DATA, d);
    hwr(HOST_CMD, {10'h000, op, i});
    idle();
  endtask
  task automatic devrd(input logic [3:0] i, input logic [15:0] e, m, input string n);
    dev(OP_READ, i, 16'h0000);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    nameQ.push_back(n);
    hrd(HOST_RDDATA);
  endtask
  // Enables from shadow registers and terminal levels
  function automatic logic [PWR_N-1:0] model();
    logic [PWR_N-1:0] p;
    logic t, r, n;
    t = pinV[LINE_TX];
    r = pinV[LINE_RX];
    n = !pinV[LINE_PD];
    p[PWR_VUL] = regs[0][0];
    p[PWR_VDL] = regs[1][0];
    p[PWR_AIF] = regs[2][0];
    p[PWR_PCTL] = regs[4][1] & (regs[4][0] | t);
    p[PWR_BBUL] = regs[5][1] & (regs[5][0] | t);
    p[PWR_CM] = regs[5][5] & (regs[5][4] | t);
    p[PWR_GAIN] = regs[4][3] & (regs[4][2] | r);
    p[PWR_BBDL] = regs[5][3] & (regs[5][2] | r);
    p[PWR_DSP] = regs[6][1] & (regs[6][0] | n);
    p[PWR_TIM] = regs[6][3] & (regs[6][2] | n);
    p[PWR_ACONV] = regs[3][1] & (regs[3][0] | n);
    p[PWR_FREQ] = regs[3][3] & (regs[3][2] | n);
    p[PWR_MIC] = regs[6][5] & (regs[6][4] | n);
    p[PWR_BG] = regs[6][6] | n;
    p[PWR_IREF] = regs[6][6] | n;
    p[PWR_SUL_BUF] = regs[0][0];
    p[PWR_SDL_BUF] = regs[1][0];
    p[PWR_MDL_BUF] = r;
    return p;
  endfunction
  task automatic status();
    logic [PWR_N-1:0] p;
    p = model();
    repeat (7) @(negedge sys_clk);
    `CHK("pwrEn", p, pwrEn)
    devrd(IDX_STAT_LO, p[15:0], 16'hFFFF, "statusLo");
    devrd(IDX_STAT_HI, {14'h0000, p[17:16]}, 16'hFFFF, "statusHi");
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Scoreboard: oldest note against the answer one cycle on
  initial begin
    logic [15:0] e, m;
    string n;
    forever begin
      @(posedge sys_clk);
      if (rdStrobe === 1'b1 && !polling) begin
        @(negedge sys_clk);
        e = expQ.pop_front();
        m = mskQ.pop_front();
        n = nameQ.pop_front();
        `CHK(n, e, rdData & m)
      end
    end
  end
  // Watchdog, far beyond the expected run
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(32'hB12B));
    foreach (regs[i]) regs[i] = 16'h0000;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    status();
    // Random bit pairs and terminals, reset line held low
    repeat (12) begin
      for (int i = 0; i < 7; i++) begin
        v = 16'($urandom) & ((16'h0001 << wid[i]) - 16'h0001);
        dev(OP_WRITE, 4'(i), v);
      end
      pinV = 4'($urandom) & 4'h7;
      hwr(HOST_PINS, {12'h000, pinV});
      status();
    end
    dev(OP_WRITE, 4'hA, 16'hFFFF);
    for (int i = 0; i < 16; i++) begin
      if (i != 7 && i != 8) devrd(4'(i), (i < 7) ? regs[i] : 16'h0000, 16'hFFFF, "reg");
    end
    // Every path code, then disabled interface
    for (int p = 0; p < 5; p++) begin
      dev(OP_WRITE, IDX_VC3, (p < 4) ? {12'h000, 2'(p), 2'b01} : 16'h000C);
      repeat (3) @(negedge sys_clk);
      `CHK("path", (p < 4) ? 2'(p) : 2'h0, pathSel)
      `CHK("routes", {p == 1 || p == 3, p == 1 || p == 2}, {up, dn})
    end
    // Serial clock runs, then reset line fall stops it
    dev(OP_WRITE, IDX_VC3, 16'h0003);
    repeat (8) if (serClk !== 1'b1) @(negedge sys_clk);
    `CHK("serialClock", 1'b1, serClk)
    pinV = 4'h8;
    hwr(HOST_PINS, {12'h000, pinV});
    repeat (6) @(posedge sys_clk);
    pinV = 4'h0;
    hwr(HOST_PINS, {12'h000, pinV});
    regs[2] = 16'h0001;
    repeat (10) @(negedge sys_clk);
    `CHK("serialStop", 1'b0, serClk)
    devrd(IDX_VC3, regs[2], 16'hFFFF, "clockStart");
    // Acoustic then vocoder entry sequences
    for (int k = 0; k < 2; k++) begin
      pth = 2'($urandom);
      dev((k == 0) ? OP_ACOUSTIC : OP_VOCODER, 4'h0, {12'h000, pth, 2'b00});
      regs[0] = (k == 0) ? 16'h0001 : 16'h0000;
      regs[1] = regs[0];
      regs[2] = {12'h000, pth, 2'b11};
      devrd(IDX_VC3, regs[2], 16'hFFFF, "testEntry");
      status();
    end
    // Second reset in mid-run
    sys_rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (regs[i]) regs[i] = 16'h0000;
    status();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
